/* File: maip_regs.vh */
// register map, field positions and reset values of the audio input port
`ifndef MAIP_REGS_VH
`define MAIP_REGS_VH
`define MAIP_ADDR_CHCTL   7'h02
`define MAIP_ADDR_IFCTL   7'h03
`define MAIP_ADDR_PWRCTL  7'h04
`define MAIP_CHCTL_RST    9'h120
`define MAIP_IFCTL_RST    9'h000
`define MAIP_PWRCTL_RST   9'h000
`define MAIP_ATC_BIT      3
`define MAIP_ROUTE_LSB    5
`define MAIP_FMT_LSB      0
`define MAIP_LRP_BIT      2
`define MAIP_BCP_BIT      3
`define MAIP_IWL_LSB      4
`define MAIP_MS_BIT       6
`define MAIP_PD_LSB       0
`define MAIP_GPD_BIT      4
`define MAIP_FMT_RJ       2'h0
`define MAIP_FMT_LJ       2'h1
`define MAIP_FMT_I2S      2'h2
`define MAIP_FMT_DSP      2'h3
`define MAIP_CW_BITS      16
`define MAIP_BCLK_DIV     8
`endif

/* File: maip_sync.v */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module maip_sync (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire pinIn,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

/* File: maip_port.v */
// eight-channel serial audio input port with 3-wire control port
//
// Notes on behaviour
// R01: master/slave bit, slave after reset, data inputs
// R02: slave samples data and word clock on rise
// R03: polarity bit moves sampling to falling edge
// R04: master drives bit clock and word clock
// R05: source changes data on falling bit clock
// R06: msb first; 16/20/24/32; rj caps at 24
// R07: source gives each phase one word length
// R08: dsp: eight channels on line one, sync
// R09: left-justified: msb first edge after transition
// R10: right-justified: lsb just before transition
// R11: i2s: msb second edge, low is left
// R12: dsp a: msb second edge after sync
// R13: dsp b: msb first edge after sync
// R14: dsp words back to back, fixed order
// R15: per-converter powerdown keeps reference alive
// R16: global powerdown overrides all, kills reference
// R17: software powers converters down before global
// R18: mode pin selects serial or strapped control
// R19: control data sampled on shift clock rise
// R20: control word: 7 address, 9 data bits
// R21: latch rising edge commits shifted word
// R22: tracking bit applies left attenuation both sides
// R23: routing field selects each output source; code stores it in chCtl_r but nothing reads it
// R24: mode pin high means hardware control
// R25: format field: rj, lj, i2s, dsp
// R26: word-clock polarity bit: dsp a/b or invert
// R27: word-length field: 16/20/24/32 bits
// R28: controller shifts msb first, then raises latch
`timescale 1ns/100ps
`default_nettype none
`include "maip_regs.vh"
module maip_port #(
  parameter BCLK_DIV = `MAIP_BCLK_DIV
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        bitClkIn,
  output wire        bitClkOut,
  output wire        bitClkOe,
  input  wire        wordClkIn,
  output wire        wordClkOut,
  output wire        wordClkOe,
  input  wire [3:0]  audioDataIn,
  input  wire        modeSelPin,
  input  wire        ctrlDataPin,
  input  wire        ctrlShiftClockPin,
  input  wire        ctrlLatchPin,
  output reg  [2:0]  sampleChan,
  output reg  [23:0] sampleLeft,
  output reg  [23:0] sampleRight,
  output wire        sampleValid,
  input  wire        sampleReady,
  output wire        attenTrackLeft,
  output reg  [3:0]  converterPowerdown,
  output wire        midrailPowerdown,
  output wire        hwMode
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire bclkS;
  wire lrckS;
  wire mdS;
  wire mcS;
  wire mlS;
  wire modeS;
  wire [3:0] dinS;
  maip_sync uBclk (.sys_clk(sys_clk), .rst_b(rst_b), .pinIn(bitClkIn),
    .level_r(bclkS));
  maip_sync uLrck (.sys_clk(sys_clk), .rst_b(rst_b), .pinIn(wordClkIn),
    .level_r(lrckS));
  maip_sync uMd (.sys_clk(sys_clk), .rst_b(rst_b), .pinIn(ctrlDataPin),
    .level_r(mdS));
  maip_sync uMc (.sys_clk(sys_clk), .rst_b(rst_b),
    .pinIn(ctrlShiftClockPin), .level_r(mcS));
  maip_sync uMl (.sys_clk(sys_clk), .rst_b(rst_b), .pinIn(ctrlLatchPin),
    .level_r(mlS));
  maip_sync uMode (.sys_clk(sys_clk), .rst_b(rst_b), .pinIn(modeSelPin),
    .level_r(modeS));
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gDin
      maip_sync uDin (.sys_clk(sys_clk), .rst_b(rst_b),
        .pinIn(audioDataIn[g]), .level_r(dinS[g]));
    end
  endgenerate

  // ------------------------------------------------------------
  // control port and registers
  // ------------------------------------------------------------
  reg [15:0] shift_r;
  reg        mcPrev_r;
  reg        mlPrev_r;
  reg [8:0]  chCtl_r;
  reg [8:0]  ifCtl_r;
  reg [8:0]  pwrCtl_r;
  assign hwMode = modeS; // R18 R24
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r  <= 16'h0000;
      mcPrev_r <= 1'b0;
      mlPrev_r <= 1'b0;
      chCtl_r  <= `MAIP_CHCTL_RST; // R23
      ifCtl_r  <= `MAIP_IFCTL_RST;
      pwrCtl_r <= `MAIP_PWRCTL_RST;
    end else begin
      mcPrev_r <= mcS;
      mlPrev_r <= mlS;
      if (!modeS && mcS && !mcPrev_r) begin
        shift_r <= {shift_r[14:0], mdS}; // R19
      end
      if (!modeS && mlS && !mlPrev_r) begin // R21
        case (shift_r[15:9]) // R20
          `MAIP_ADDR_CHCTL:  chCtl_r  <= shift_r[8:0];
          `MAIP_ADDR_IFCTL:  ifCtl_r  <= shift_r[8:0];
          `MAIP_ADDR_PWRCTL: pwrCtl_r <= shift_r[8:0];
          default:           chCtl_r  <= chCtl_r;
        endcase
      end
    end
  end

  // hardware mode: latch pin picks i2s or rj, latch and shift clock pins together pick length
  wire [1:0] fmt;
  wire [1:0] word_length_select;
  wire       wordclk_polarity;
  wire       bitclk_polarity;
  wire       master;
  assign fmt    = modeS ? (mlS ? `MAIP_FMT_I2S : `MAIP_FMT_RJ)
                        : ifCtl_r[`MAIP_FMT_LSB +: 2]; // R25
  assign word_length_select    = modeS ? (mlS ? (mcS ? 2'h2 : 2'h0) : (mcS ? 2'h1 : 2'h2))
                        : ifCtl_r[`MAIP_IWL_LSB +: 2]; // R27
  assign wordclk_polarity    = modeS ? 1'b0 : ifCtl_r[`MAIP_LRP_BIT];
  assign bitclk_polarity    = modeS ? 1'b0 : ifCtl_r[`MAIP_BCP_BIT];
  assign master = modeS ? 1'b0 : ifCtl_r[`MAIP_MS_BIT]; // R01
  assign attenTrackLeft = chCtl_r[`MAIP_ATC_BIT]; // R22
  assign midrailPowerdown = pwrCtl_r[`MAIP_GPD_BIT]; // R16
  always @* begin
    converterPowerdown = pwrCtl_r[`MAIP_PD_LSB +: 4]; // R15
    if (pwrCtl_r[`MAIP_GPD_BIT]) begin
      converterPowerdown = 4'hf; // R16
    end
  end

  // word length in bits; right-justified 32 falls back to 24
  reg [5:0] wlen;
  always @* begin
    case (word_length_select) // R27
      2'h0:    wlen = 6'd16;
      2'h1:    wlen = 6'd20;
      2'h2:    wlen = 6'd24;
      default: wlen = (fmt == `MAIP_FMT_RJ) ? 6'd24 : 6'd32; // R06
    endcase
  end

  // ------------------------------------------------------------
  // master clock generation
  // ------------------------------------------------------------
  reg [7:0] div_r;
  reg       bclkGen_r;
  reg [8:0] bitCnt_r;
  reg       lrckGen_r;
  wire [8:0] halfLen;
  assign halfLen = (fmt == `MAIP_FMT_DSP) ? {wlen, 3'h0} : {3'h0, wlen};
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r     <= 8'h00;
      bclkGen_r <= 1'b0;
      bitCnt_r  <= 9'h000;
      lrckGen_r <= 1'b0;
    end else if (master) begin // R04
      if (div_r == BCLK_DIV[7:0] - 8'h01) begin
        div_r     <= 8'h00;
        bclkGen_r <= ~bclkGen_r;
        if (bclkGen_r) begin
          // word clock changes on falling bit clock
          if (fmt == `MAIP_FMT_DSP) begin
            bitCnt_r  <= (bitCnt_r == halfLen - 9'h001) ? 9'h000
                         : bitCnt_r + 9'h001;
            lrckGen_r <= (bitCnt_r == halfLen - 9'h001);
          end else if (bitCnt_r == halfLen - 9'h001) begin
            bitCnt_r  <= 9'h000;
            lrckGen_r <= ~lrckGen_r;
          end else begin
            bitCnt_r <= bitCnt_r + 9'h001;
          end
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end else begin
      div_r     <= 8'h00;
      bclkGen_r <= 1'b0;
      bitCnt_r  <= 9'h000;
      lrckGen_r <= 1'b0;
    end
  end
  assign bitClkOut  = bclkGen_r ^ bitclk_polarity;
  assign bitClkOe   = master; // R04
  assign wordClkOut = lrckGen_r;
  assign wordClkOe  = master;

  // ------------------------------------------------------------
  // bit-clock edge detection and framing
  // ------------------------------------------------------------
  reg  bclkPrev_r;
  wire bclkNow;
  wire sampleEdge;
  assign bclkNow = master ? bclkGen_r : bclkS; // R02
  // in master mode the generated rise is seen in the same cycle it drives
  assign sampleEdge = bitclk_polarity ? (bclkPrev_r && !bclkNow)
                          : (!bclkPrev_r && bclkNow); // R03
  wire lrckRaw;
  assign lrckRaw = master ? lrckGen_r : lrckS;
  reg        lrPrev_r;
  reg [5:0]  cnt_r;
  reg [2:0]  slot_r;
  reg        skip_r;
  reg        active_r;
  reg [31:0] sh_r [0:3];
  reg [23:0] wordL_r [0:3];
  reg [23:0] wordR_r [0:3];
  reg        frameDone_r;
  reg [3:0]  dspMask_r;
  wire       lrIsLeft;
  // i2s inverts the sense; lrp inverts it again outside dsp
  assign lrIsLeft = (lrPrev_r ^ (fmt == `MAIP_FMT_I2S)) ^ wordclk_polarity; // R11 R26
  wire lrEdge;
  assign lrEdge = (lrckRaw != lrPrev_r);
  wire [23:0] fit [0:3];
  generate
    for (g = 0; g < 4; g = g + 1) begin : gFit
      // left-align into 24 bits: pad short words, drop extra lsbs
      assign fit[g] = (wlen == 6'd32) ? sh_r[g][31:8]
                    : (wlen == 6'd24) ? sh_r[g][23:0]
                    : (wlen == 6'd20) ? {sh_r[g][19:0], 4'h0}
                    : {sh_r[g][15:0], 8'h00}; // R06
    end
  endgenerate
  integer i;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bclkPrev_r  <= 1'b0;
      lrPrev_r    <= 1'b0;
      cnt_r       <= 6'h00;
      slot_r      <= 3'h0;
      skip_r      <= 1'b0;
      active_r    <= 1'b0;
      frameDone_r <= 1'b0;
      dspMask_r   <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        sh_r[i]    <= 32'h0000_0000;
        wordL_r[i] <= 24'h000000;
        wordR_r[i] <= 24'h000000;
      end
    end else begin
      bclkPrev_r  <= bclkNow;
      frameDone_r <= 1'b0;
      if (sampleEdge) begin
        lrPrev_r <= lrckRaw;
        for (i = 0; i < 4; i = i + 1) begin
          sh_r[i] <= {sh_r[i][30:0], dinS[i]}; // R06
        end
        if (fmt == `MAIP_FMT_RJ) begin
          if (lrEdge) begin // R10
            for (i = 0; i < 4; i = i + 1) begin
              if (lrIsLeft) wordL_r[i] <= fit[i];
              else          wordR_r[i] <= fit[i];
            end
            frameDone_r <= !lrIsLeft;
            dspMask_r   <= 4'hf;
          end
        end else if (fmt == `MAIP_FMT_DSP) begin // R08
          if (lrckRaw && !lrPrev_r) begin
            skip_r   <= !wordclk_polarity; // R12 R13
            active_r <= wordclk_polarity;
            cnt_r    <= 6'h00;
            slot_r   <= 3'h0;
          end else if (skip_r) begin
            skip_r   <= 1'b0;
            active_r <= 1'b1;
          end
          if (active_r || (lrckRaw && !lrPrev_r && wordclk_polarity)) begin
            if (cnt_r == wlen - 6'h01 && !(lrckRaw && !lrPrev_r)) begin
              cnt_r  <= 6'h00;
              slot_r <= slot_r + 3'h1; // R14
              if (slot_r[0]) wordR_r[slot_r[2:1]] <= fit[0];
              else           wordL_r[slot_r[2:1]] <= fit[0];
              if (slot_r == 3'h7) begin
                active_r    <= 1'b0;
                frameDone_r <= 1'b1;
                dspMask_r   <= 4'hf;
              end
            end else if (!(lrckRaw && !lrPrev_r)) begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end else begin
          // lj: msb on first edge, i2s: one spare edge first
          if (lrEdge) begin
            skip_r   <= (fmt == `MAIP_FMT_I2S); // R11
            active_r <= (fmt == `MAIP_FMT_LJ); // R09
            cnt_r    <= 6'h00;
          end else if (skip_r) begin
            skip_r   <= 1'b0;
            active_r <= 1'b1;
          end
          if ((active_r && !lrEdge) || (lrEdge && fmt == `MAIP_FMT_LJ))
          begin
            if (cnt_r == wlen - 6'h01 && active_r && !lrEdge) begin
              active_r <= 1'b0;
              for (i = 0; i < 4; i = i + 1) begin
                if ((lrckRaw ^ (fmt == `MAIP_FMT_I2S)) ^ wordclk_polarity)
                  wordL_r[i] <= fit[i];
                else
                  wordR_r[i] <= fit[i];
              end
              frameDone_r <= !((lrckRaw ^ (fmt == `MAIP_FMT_I2S)) ^ wordclk_polarity);
              dspMask_r   <= 4'hf;
            end else if (!lrEdge) begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // two-entry output buffer: each entry holds one converter's left and right words
  // ------------------------------------------------------------
  reg [50:0] buf_r [0:1];
  reg        wp_r;
  reg        rp_r;
  reg [1:0]  cnt2_r;
  reg [3:0]  pend_r;
  reg [1:0]  pick;
  wire       bufFull;
  wire       push;
  wire [50:0] pushWord;
  assign bufFull = (cnt2_r == 2'h2);
  assign pushWord = {1'b0, pick, wordL_r[pick], wordR_r[pick]};
  always @* begin
    pick = 2'h0;
    if (!pend_r[0]) pick = pend_r[1] ? 2'h1 : (pend_r[2] ? 2'h2 : 2'h3);
  end
  assign push = (pend_r != 4'h0) && !bufFull;
  assign sampleValid = (cnt2_r != 2'h0);
  wire pop;
  assign pop = sampleValid && sampleReady;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r        <= 1'b0;
      rp_r        <= 1'b0;
      cnt2_r      <= 2'h0;
      pend_r      <= 4'h0;
      buf_r[0]    <= 51'h0;
      buf_r[1]    <= 51'h0;
      sampleChan  <= 3'h0;
      sampleLeft  <= 24'h000000;
      sampleRight <= 24'h000000;
    end else begin
      // a new frame while words wait marks all four converters pending again
      if (frameDone_r) pend_r <= dspMask_r;
      else if (push)   pend_r <= pend_r & ~(4'h1 << pick);
      if (push) begin
        buf_r[wp_r] <= pushWord;
        wp_r        <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt2_r <= cnt2_r + {1'b0, push} - {1'b0, pop};
      // head registers load with the entry so data stands with valid
      if ((cnt2_r == 2'h0 && push) || (cnt2_r == 2'h1 && pop && push)) begin
        {sampleChan, sampleLeft, sampleRight} <= pushWord;
      end else if (pop) begin
        {sampleChan, sampleLeft, sampleRight} <= buf_r[~rp_r];
      end
    end
  end
endmodule
`default_nettype wire

/* File: maip_chk.sv */
// assertions watching the audio input port pins
`timescale 1ns/100ps
`default_nettype none
module maip_chk #(
  parameter BCLK_DIV = 8
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        modeSelPin,
  input wire logic        sampleReady,
  input wire logic        bitClkOut,
  input wire logic        bitClkOe,
  input wire logic        wordClkOe,
  input wire logic [2:0]  sampleChan,
  input wire logic [23:0] sampleLeft,
  input wire logic        sampleValid,
  input wire logic [3:0]  converterPowerdown,
  input wire logic        midrailPowerdown,
  input wire logic        hwMode
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  logic [7:0] hold_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // cycles the generated bit clock has sat at one level
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      hold_r <= 8'h0;
    else
      hold_r <= (bitClkOe && $stable(bitClkOut)) ? hold_r + 8'h1 : 8'h0;
  end
  oe_pair_a: assert property (bitClkOe == wordClkOe)
    else $error("bit and word clock enables differ");
  bclk_run_a: assert property (hold_r <= BCLK_DIV)
    else $error("master bit clock half period too long");
  rst_idle_a: assert property ($rose(rst_b) |-> !bitClkOe &&
    !sampleValid && converterPowerdown == 4'h0)
    else $error("port not idle after reset");
  hw_slave_a: assert property (hwMode [*4] |-> !bitClkOe)
    else $error("clocks driven in hardware mode");
  hw_follow_a: assert property ($rose(modeSelPin) |-> ##[1:6] hwMode)
    else $error("hardware mode not entered");
  sw_follow_a: assert property ($fell(modeSelPin) |-> ##[1:6] !hwMode)
    else $error("software mode not entered");
  chan_range_a: assert property (sampleValid |-> sampleChan <= 3'h3)
    else $error("converter index out of range");
  hold_data_a: assert property (sampleValid && !sampleReady |=>
    sampleValid && $stable(sampleLeft) && $stable(sampleChan))
    else $error("stalled sample changed");
  cover property (sampleValid && sampleReady);
  cover property (bitClkOe);
  cover property (midrailPowerdown);
  cover property (hwMode);
endmodule
bind maip_port maip_chk #(.BCLK_DIV(BCLK_DIV)) u_maip_chk (.sys_clk,
  .rst_b, .modeSelPin, .sampleReady, .bitClkOut, .bitClkOe, .wordClkOe,
  .sampleChan, .sampleLeft, .sampleValid, .converterPowerdown,
  .midrailPowerdown, .hwMode);
`default_nettype wire

/* File: maip_src.sv */
// behavioural audio source and control processor on the port pins
`timescale 1ns/100ps
`default_nettype none
module maip_src (
  output logic       bitClkIn,
  output logic       wordClkIn,
  output logic [3:0] audioDataIn,
  output logic       ctrlDataPin,
  output logic       ctrlShiftClockPin,
  output logic       ctrlLatchPin
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic pol = 1'b0;
  logic raw = 1'b0;
  assign bitClkIn = raw ^ pol;
  initial begin
    wordClkIn = 1'b0;
    audioDataIn = 4'h0;
    ctrlDataPin = 1'b0;
    ctrlShiftClockPin = 1'b0;
    ctrlLatchPin = 1'b0;
  end
  function [31:0] wv(input [2:0] idx, input [31:0] base);
    wv = base ^ ({29'h0, idx} * 32'h11111111);
  endfunction
  // one bit clock, data moved on the non-sampling edge
  task bitOut(input wc, input [3:0] d);
    begin
      wordClkIn = wc;
      audioDataIn = d;
      #16 raw = 1'b1;
      #16 raw = 1'b0;
    end
  endtask
  // dummy right phase (dsp: h idle bits with word clock low), then one frame; bit clock stops afterwards
  task frame(input [1:0] fmt, input wordclk_polarity, input bitclk_polarity, input integer wl,
             input [31:0] base);
    integer i, n, h, off, p, j, c;
    logic ll;
    logic [3:0] d;
    logic [31:0] w;
    begin
      pol = bitclk_polarity;
      h = wl + 2;
      ll = ~((fmt == 2'h2) ^ wordclk_polarity);
      off = (fmt == 2'h2) ? 1 : (fmt == 2'h0) ? h - wl : 0;
      if (fmt == 2'h3)
        off = wordclk_polarity ? 0 : 1;
      n = (fmt == 2'h3) ? h + 8 * wl + off + 2 : 3 * h + 1;
      for (i = 0; i < n; i = i + 1) begin
        d = {4{i[0]}} ^ 4'h5;
        if (fmt == 2'h3) begin
          j = i - h - off;
          w = wv(3'(j / wl), base);
          if (j >= 0 && j < 8 * wl)
            d[0] = w[wl - 1 - j % wl];
          bitOut(i == h, d);
        end else begin
          p = i / h;
          j = i % h - off;
          for (c = 0; c < 4; c = c + 1) begin
            w = wv(3'(2 * c + (p == 2)), base);
            if ((p == 1 || p == 2) && j >= 0 && j < wl)
              d[c] = w[wl - 1 - j];
          end
          bitOut((p == 1 || p == 3) ? ll : ~ll, d);
        end
      end
      audioDataIn = ~audioDataIn;
    end
  endtask
  task wr(input [6:0] a, input [8:0] v);
    integer b;
    logic [15:0] cw;
    begin
      cw = {a, v};
      for (b = 15; b >= 0; b = b - 1) begin
        ctrlDataPin = cw[b];
        #16 ctrlShiftClockPin = 1'b1;
        #16 ctrlShiftClockPin = 1'b0;
      end
      ctrlDataPin = ~cw[0];
      ctrlLatchPin = 1'b1;
      #32 ctrlLatchPin = 1'b0;
      #32;
    end
  endtask
endmodule
`default_nettype wire

/* File: test_maip_port.sv */
// self-checking bench for the audio input port
`timescale 1ns/100ps
`default_nettype none
module test_maip_port;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam int DIV = 8;
  localparam [35:0] CASES = {6'h3c, 6'h32, 6'h21, 6'h27, 6'h0a, 6'h10};
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       modeSelPin = 1'b0;
  logic       sampleReady = 1'b0;
  wire        bitClkIn, bitClkOut, bitClkOe, wordClkIn, wordClkOut;
  wire        wordClkOe, ctrlDataPin, ctrlShiftClockPin, ctrlLatchPin;
  wire        sampleValid, attenTrackLeft, midrailPowerdown, hwMode;
  wire [3:0]  audioDataIn, converterPowerdown;
  wire [2:0]  sampleChan;
  wire [23:0] sampleLeft, sampleRight;
  int         error_cnt = 0;
  int         n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  maip_port #(.BCLK_DIV(DIV)) u_maip_port (.sys_clk, .rst_b, .bitClkIn,
    .bitClkOut, .bitClkOe, .wordClkIn, .wordClkOut, .wordClkOe,
    .audioDataIn, .modeSelPin, .ctrlDataPin, .ctrlShiftClockPin,
    .ctrlLatchPin, .sampleChan, .sampleLeft, .sampleRight, .sampleValid,
    .sampleReady, .attenTrackLeft, .converterPowerdown, .midrailPowerdown,
    .hwMode);
  maip_src u_maip_src (.bitClkIn, .wordClkIn, .audioDataIn, .ctrlDataPin,
    .ctrlShiftClockPin, .ctrlLatchPin);
  task print_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function [23:0] exp24(input [31:0] w, input integer wl);
    logic [31:0] s;
    s = w << (32 - wl);
    exp24 = s[31:8];
  endfunction
  task pop(input [2:0] ch, input [23:0] l, input [23:0] r);
    int k;
    for (k = 0; k < 4000 && sampleValid !== 1'b1; k++)
      @(negedge sys_clk);
    if (k >= 4000) begin
      error_cnt++;
      $display("Error at %0t: no sample", $time);
      print_verdict;
    end
    chk(32'(sampleChan), 32'(ch));
    chk(32'(sampleLeft), 32'(l));
    chk(32'(sampleRight), 32'(r));
    sampleReady = 1'b1;
    @(negedge sys_clk);
    sampleReady = 1'b0;
    @(negedge sys_clk);
  endtask
  task t_reset;
    chk(32'(bitClkOe), 0);
    chk(32'(wordClkOe), 0);
    chk(32'(sampleValid), 0);
    chk(32'(attenTrackLeft), 0);
    chk(32'(hwMode), 0);
  endtask
  task t_power;
    u_maip_src.wr(7'h04, 9'h00a);
    chk(32'(converterPowerdown), 32'h0a);
    chk(32'(midrailPowerdown), 0);
    u_maip_src.wr(7'h04, 9'h01a);
    chk(32'(midrailPowerdown), 1);
    chk(32'(converterPowerdown), 32'h0f);
    u_maip_src.wr(7'h04, 9'h000);
    chk(32'(midrailPowerdown), 0);
  endtask
  task t_ctrl;
    u_maip_src.wr(7'h02, 9'h128);
    chk(32'(attenTrackLeft), 1);
    u_maip_src.wr(7'h42, 9'h000);
    chk(32'(attenTrackLeft), 1);
    modeSelPin = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(32'(hwMode), 1);
    u_maip_src.wr(7'h02, 9'h120);
    chk(32'(attenTrackLeft), 1);
    modeSelPin = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(32'(hwMode), 0);
    u_maip_src.wr(7'h02, 9'h120);
    chk(32'(attenTrackLeft), 0);
  endtask
  // each format in turn; consumer stalls while two entries queue and two words wait pending
  task t_audio;
    int k, wl, c;
    logic [5:0] e;
    logic [31:0] b;
    for (k = 0; k < 6; k++) begin
      e = CASES[6 * k +: 6];
      wl = (e[1:0] == 2'h3) ? 32 : 16 + 4 * e[1:0];
      b = 32'h9c3a5e17 ^ k;
      u_maip_src.wr(7'h03, {3'h0, e[1:0], e[2], e[3], e[5:4]});
      fork
        u_maip_src.frame(e[5:4], e[3], e[2], wl, b);
        begin
          sampleReady = 1'b1;
          repeat ((e[5:4] == 2'h3 ? 8 : 16) * (wl + 2)) @(negedge sys_clk);
          sampleReady = 1'b0;
        end
      join
      repeat (100) @(negedge sys_clk);
      for (c = 0; c < 4; c++)
        pop(3'(c), exp24(u_maip_src.wv(3'(2 * c), b), wl),
            exp24(u_maip_src.wv(3'(2 * c + 1), b), wl));
    end
  endtask
  task t_master;
    int k;
    logic t0;
    u_maip_src.wr(7'h03, 9'h040);
    chk(32'(bitClkOe), 1);
    chk(32'(wordClkOe), 1);
    repeat (2) begin
      t0 = bitClkOut;
      for (k = 0; k < 40 && bitClkOut === t0; k++)
        @(negedge sys_clk);
    end
    chk(32'(k), DIV);
    repeat (2) begin
      t0 = wordClkOut;
      for (k = 0; k < 600 && wordClkOut === t0; k++)
        @(negedge sys_clk);
    end
    chk(32'(k), 32 * DIV);
    u_maip_src.wr(7'h03, 9'h000);
    chk(32'(bitClkOe), 0);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_power;
    t_ctrl;
    t_audio;
    t_master;
    print_verdict;
  end
endmodule
`default_nettype wire
